// *** ddrrd_pkg.sv ***
// shared constants and types for the ddr3 read-path host controller
package ddrrd_pkg;

    // clocking: the memory clock is the system clock divided down
    localparam int MCLK_NS = 40;
    localparam int CK_DIV = 4;
    localparam int CK_NS = MCLK_NS * CK_DIV;

    // analog minimums, in ns
    localparam int T_RTP_NS = 8;
    localparam int T_RP_NS = 14;

    // analog minimums converted to memory clocks, rounded up
    localparam int RTP_CK = (T_RTP_NS + CK_NS - 1) / CK_NS;
    localparam int RP_CK = (T_RP_NS + CK_NS - 1) / CK_NS;

    // command spacing figures, in memory clocks
    localparam int CCD_CK = 4;
    localparam int PRE_MIN_CK = 4;
    localparam int RW_EXTRA_CK = 2;

    // the device never precharges sooner than four clocks after the read
    localparam int RTP_EFF_NS = (T_RTP_NS > PRE_MIN_CK * CK_NS) ?
                                T_RTP_NS : PRE_MIN_CK * CK_NS;
    localparam int RTP_RP_CK = (RTP_EFF_NS + T_RP_NS + CK_NS - 1) / CK_NS;

    // geometry
    localparam int NUM_BANKS = 8;
    localparam int BA_W = 3;
    localparam int ADDR_W = 14;
    localparam int CNT_W = 8;
    localparam int A10_BIT = 10;
    localparam int A12_BIT = 12;

    // burst-length mode field
    localparam logic [1:0] BLM_FIX8 = 2'h0;
    localparam logic [1:0] BLM_OTF = 2'h1;
    localparam logic [1:0] BLM_FIX4 = 2'h2;

    // {ras_n, cas_n, we_n} encodings
    localparam logic [2:0] RCW_NOP = 3'h7;
    localparam logic [2:0] RCW_ACT = 3'h3;
    localparam logic [2:0] RCW_RD = 3'h5;
    localparam logic [2:0] RCW_WR = 3'h4;
    localparam logic [2:0] RCW_PRE = 3'h2;

    typedef enum logic [1:0] {
        DDRRD_RD = 2'h0,
        DDRRD_WR = 2'h1,
        DDRRD_PRE = 2'h2,
        DDRRD_ACT = 2'h3
    } ddrrd_kind_t;

    typedef struct packed {
        ddrrd_kind_t kind;
        logic [BA_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic ap;
        logic bl8;
    } ddrrd_req_t;

    typedef struct packed {
        logic cs_n;
        logic [2:0] rcw;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } ddrrd_cmd_t;

    localparam ddrrd_cmd_t CMD_IDLE = '{cs_n: 1'b1, rcw: RCW_NOP,
        ba: '0, addr: '0};

    typedef enum logic [3:0] {
        PH_RISE = 4'h1,
        PH_HIGH = 4'h2,
        PH_FALL = 4'h4,
        PH_LOW = 4'h8
    } ddrrd_phase_t;

    // burst of eight unless chopped by mode or on-the-fly bit
    function automatic logic is_bl8(input logic [1:0] mode,
                                    input logic otf8);
        return (mode == BLM_FIX8) || ((mode == BLM_OTF) && otf8);
    endfunction

endpackage

// *** ddrrd_host.sv ***
// ddr3 read-path host controller: command spacing and strobe capture
//
// Summary of operation
// - READ at column-to-column interval gives gapless back-to-back bursts.
// - Chopped bursts still keep the column interval; the data shows a gap.
// - Never interrupt or truncate a read burst in progress.
// - READ to WRITE spacing at least RL + tCCD - WL + 2 clocks.
// - PRECHARGE after READ waits four clocks and the read-to-precharge time.
// - Read-to-precharge time counts from AL cycles after the READ.
// - After PRECHARGE, no READ or ACTIVATE to that bank until tRP elapses.
// - Repeat PRECHARGE allowed; precharge period runs from the last one.
// - A pushed-out internal precharge is not tracked; the auto-precharge wait is a fixed AL + RTP_RP_CK.
// - After auto-precharge READ, ACTIVATE waits AL + ceil(max(tRTP, four clocks) + tRP).
// - Burst eight for mode 00 or 01 with bit 12 high, else four.
// - Read data is captured with the strobe edges, not the clock.
`timescale 1ns/10ps
module ddrrd_host
    import ddrrd_pkg::*;
#(
    parameter int DQ_W = 8,
    parameter int CL = 5,
    parameter int AL = 0,
    parameter int CWL = 5
) (
    // system
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // user request port
    input wire logic req_valid_i,
    input wire ddrrd_req_t req_i,
    output logic req_ready_o,
    input wire logic [1:0] mode_bl_i,
    // read data to user
    output logic rd_valid_o,
    output logic [2*DQ_W-1:0] rd_data_o,
    // memory pins
    output logic ck_o,
    output logic ck_n_o,
    output logic cke_o,
    output ddrrd_cmd_t cmd_o,
    input wire logic dqs_i,
    input wire logic [DQ_W-1:0] dq_i
);

    localparam int RL = AL + CL;
    localparam int WL = AL + CWL;
    localparam int RW_GAP = RL + CCD_CK - WL + RW_EXTRA_CK;
    localparam int PRE_GAP = (AL + RTP_CK > PRE_MIN_CK) ?
                             AL + RTP_CK : PRE_MIN_CK;
    localparam int RDA_GAP = AL + RTP_RP_CK;

    // counters hold remaining clocks minus one, zero means allowed
    localparam logic [CNT_W-1:0] LD_CCD = CNT_W'(CCD_CK - 1);
    localparam logic [CNT_W-1:0] LD_RW = CNT_W'(RW_GAP - 1);
    localparam logic [CNT_W-1:0] LD_PRE = CNT_W'(PRE_GAP - 1);
    localparam logic [CNT_W-1:0] LD_RP = CNT_W'(RP_CK - 1);
    localparam logic [CNT_W-1:0] LD_RDA = CNT_W'(RDA_GAP - 1);

    typedef struct packed {
        ddrrd_phase_t phase;
        logic ck;
        logic cke;
        ddrrd_cmd_t cmd;
        logic [CNT_W-1:0] ccd;
        logic [CNT_W-1:0] rw;
        logic [NUM_BANKS-1:0][CNT_W-1:0] pre;
        logic [NUM_BANKS-1:0][CNT_W-1:0] busy;
        logic tog_s1;
        logic tog_s2;
        logic tog_seen;
        logic rd_valid;
        logic [2*DQ_W-1:0] rd_data;
    } ddrrd_st_t;

    localparam ddrrd_st_t ST_RST = '{phase: PH_RISE, ck: 1'b1,
        cke: 1'b0, cmd: CMD_IDLE, ccd: '0, rw: '0, pre: '0, busy: '0,
        tog_s1: 1'b0, tog_s2: 1'b0, tog_seen: 1'b0, rd_valid: 1'b0,
        rd_data: '0};

    function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
        return (v == '0) ? v : v - CNT_W'(1);
    endfunction

    // a later read never shortens a running wait; a precharge reloads busy outright
    function automatic logic [CNT_W-1:0] keep_max(
        input logic [CNT_W-1:0] cur,
        input logic [CNT_W-1:0] ld);
        return (cur > ld) ? cur : ld;
    endfunction

    ddrrd_st_t st;
    ddrrd_st_t next_st;
    logic ok;
    logic slot;

    // strobe-domain capture
    logic [DQ_W-1:0] rise_q;
    logic [2*DQ_W-1:0] pair_q;
    logic tog_dqs;

    // each data element sits on its own strobe edge
    always_ff @(posedge dqs_i) begin
        rise_q <= dq_i;
    end

    always_ff @(negedge dqs_i) begin
        pair_q <= {dq_i, rise_q};
    end

    // strobe stands still at reset, so the clear must not need an edge
    always_ff @(negedge dqs_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tog_dqs <= 1'b0;
        end else begin
            tog_dqs <= ~tog_dqs;
        end
    end

    // one command slot per memory clock, taken just before ck falls
    assign slot = (st.phase == PH_HIGH);

    always_comb begin
        ok = 1'b0;
        case (req_i.kind)
            DDRRD_RD: begin
                // column interval even for chopped bursts
                ok = (st.ccd == '0) && (st.busy[req_i.bank] == '0);
            end
            DDRRD_WR: begin
                ok = (st.ccd == '0) && (st.rw == '0);
            end
            DDRRD_PRE: begin
                // repeat precharge allowed while precharging
                ok = (st.pre[req_i.bank] == '0);
            end
            DDRRD_ACT: begin
                ok = (st.busy[req_i.bank] == '0);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
    end

    assign req_ready_o = slot && ok;

    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        next_st.cke = 1'b1;
        case (st.phase)
            PH_RISE: begin
                next_st.phase = PH_HIGH;
            end
            PH_HIGH: begin
                next_st.phase = PH_FALL;
            end
            PH_FALL: begin
                next_st.phase = PH_LOW;
            end
            PH_LOW: begin
                next_st.phase = PH_RISE;
            end
            default: begin
                next_st.phase = PH_RISE;
            end
        endcase
        next_st.ck = (next_st.phase == PH_RISE) ||
                     (next_st.phase == PH_HIGH);

        if (slot) begin
            next_st.cmd.cs_n = 1'b1;
            next_st.cmd.rcw = RCW_NOP;
            next_st.ccd = dec(st.ccd);
            next_st.rw = dec(st.rw);
            for (int b = 0; b < NUM_BANKS; b++) begin
                next_st.pre[b] = dec(st.pre[b]);
                next_st.busy[b] = dec(st.busy[b]);
            end
            if (req_valid_i && ok) begin
                next_st.cmd.cs_n = 1'b0;
                next_st.cmd.ba = req_i.bank;
                next_st.cmd.addr = req_i.addr;
                case (req_i.kind)
                    DDRRD_RD: begin
                        next_st.cmd.rcw = RCW_RD;
                        next_st.cmd.addr[A10_BIT] = req_i.ap;
                        next_st.cmd.addr[A12_BIT] =
                            is_bl8(mode_bl_i, req_i.bl8);
                        next_st.ccd = LD_CCD;
                        next_st.rw = LD_RW;
                        // wait starts AL later, plus four-clock floor
                        next_st.pre[req_i.bank] =
                            keep_max(dec(st.pre[req_i.bank]),
                                     LD_PRE);
                        if (req_i.ap) begin
                            // device may push its precharge out
                            next_st.busy[req_i.bank] =
                                keep_max(dec(st.busy[req_i.bank]),
                                         LD_RDA);
                        end
                    end
                    DDRRD_WR: begin
                        next_st.cmd.rcw = RCW_WR;
                        next_st.cmd.addr[A10_BIT] = 1'b0;
                        next_st.ccd = LD_CCD;
                    end
                    DDRRD_PRE: begin
                        next_st.cmd.rcw = RCW_PRE;
                        next_st.cmd.addr[A10_BIT] = 1'b0;
                        next_st.busy[req_i.bank] = LD_RP;
                    end
                    DDRRD_ACT: begin
                        next_st.cmd.rcw = RCW_ACT;
                    end
                    default: begin
                        next_st.cmd.rcw = RCW_NOP;
                    end
                endcase
            end
        end

        // pair word is stable a whole strobe period after its toggle
        next_st.tog_s1 = tog_dqs;
        next_st.tog_s2 = st.tog_s1;
        if (st.tog_s2 != st.tog_seen) begin
            next_st.tog_seen = st.tog_s2;
            next_st.rd_valid = 1'b1;
            next_st.rd_data = pair_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign ck_o = st.ck;
    assign ck_n_o = ~st.ck;
    assign cke_o = st.cke;
    assign cmd_o = st.cmd;
    assign rd_valid_o = st.rd_valid;
    assign rd_data_o = st.rd_data;

endmodule // ddrrd_host

// *** ddrrd_chk.sv ***
// port assertions for the ddr3 read-path host
`timescale 1ns/10ps
module ddrrd_chk
    import ddrrd_pkg::*;
#(
    parameter int CL = 5,
    parameter int AL = 0,
    parameter int CWL = 5
) (
    // watched host ports
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire ddrrd_req_t req_i,
    input wire logic req_ready_o,
    input wire logic [1:0] mode_bl_i,
    input wire logic rd_valid_o,
    input wire logic cke_o,
    input wire logic ck_o,
    input wire logic ck_n_o,
    input wire ddrrd_cmd_t cmd_o,
    input wire logic dqs_i
);
    localparam int G_CCD = CCD_CK * CK_DIV;
    localparam int G_RW = (CL + AL + CCD_CK - CWL + RW_EXTRA_CK) * CK_DIV;
    localparam int G_PRE = PRE_MIN_CK * CK_DIV;
    logic ck_q;
    logic [7:0] age;
    logic [BA_W-1:0] rba;
    wire new_rd = ck_q && !ck_o && !cmd_o.cs_n && cmd_o.rcw == RCW_RD;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_take(k);
        req_valid_i && req_ready_o && req_i.kind == k;
    endsequence
    sequence s_new(r);
        $fell(ck_o) && !cmd_o.cs_n && cmd_o.rcw == r;
    endsequence
    // mclk cycles since the last read went out, saturating
    always_ff @(posedge mclk_i) begin
        ck_q <= ck_o;
        if (!rst_n_i) begin
            age <= 8'hff;
        end else if (new_rd) begin
            age <= 8'h01;
            rba <= cmd_o.ba;
        end else if (age != 8'hff) begin
            age <= age + 8'h01;
        end
    end
    rd_issue_a: assert property (s_take(DDRRD_RD) |=>
        !cmd_o.cs_n && cmd_o.rcw == RCW_RD &&
        cmd_o.addr[A10_BIT] == $past(req_i.ap))
        else $error("read command or auto precharge bit wrong");
    otf_len_a: assert property (
        s_take(DDRRD_RD) ##0 mode_bl_i == BLM_OTF |=>
        cmd_o.addr[A12_BIT] == $past(req_i.bl8))
        else $error("burst length bit wrong");
    ccd_gap_a: assert property (s_new(RCW_RD) |-> age >= G_CCD)
        else $error("reads closer than column interval");
    rd_wr_gap_a: assert property (s_new(RCW_WR) |-> age >= G_RW)
        else $error("write too soon after read");
    rd_pre_gap_a: assert property (
        s_new(RCW_PRE) ##0 cmd_o.ba == rba |-> age >= G_PRE)
        else $error("precharge too soon after read");
    cmd_hold_a: assert property (
        $fell(ck_o) && !cmd_o.cs_n |=> $stable(cmd_o)[*3])
        else $error("command did not stand one memory clock");
    cmd_edge_a: assert property ($changed(cmd_o) |-> $fell(ck_o))
        else $error("command changed off the clock fall");
    ck_form_a: assert property ($rose(ck_o) |->
        !ck_n_o ##1 ck_o ##1 !ck_o)
        else $error("memory clock shape wrong");
    cke_up_a: assert property ($past(rst_n_i) |-> cke_o)
        else $error("clock enable not high after reset");
    cap_pulse_a: assert property ($fell(dqs_i) |-> ##[1:4] rd_valid_o)
        else $error("strobe fall not captured");
endmodule // ddrrd_chk

// *** ddrrd_dev.sv ***
// behavioural ddr3 device answering reads on strobe and data
`timescale 1ns/10ps
module ddrrd_dev
    import ddrrd_pkg::*;
#(
    parameter int RL = 5,
    parameter int AL = 0,
    parameter int RAS_CK = 4,
    parameter int DQ_W = 8
) (
    // pins from the host
    input wire logic ck_i,
    input wire ddrrd_cmd_t cmd_i,
    input wire logic [1:0] mode_i,
    // strobe and data to the host
    output logic dqs_o,
    output logic [DQ_W-1:0] dq_o
);
    int busy = 0;
    int act_early = 0;
    time act_t[NUM_BANKS];
    time ready_t[NUM_BANKS];
    time p_at;
    // strobe idles terminated low so the host sees no stray capture edge
    initial begin
        dqs_o = 1'b0;
        dq_o = '0;
    end
    task automatic burst(input logic [7:0] col, input logic a12);
        int n;
        n = (mode_i == BLM_FIX8 || (mode_i == BLM_OTF && a12)) ? 8 : 4;
        #(RL * CK_NS); // low preamble, then first element
        for (int i = 0; i < n; i++) begin
            dq_o = DQ_W'(col + 8'(i)); // one element per ck edge
            #(CK_NS / 4) dqs_o = ~i[0]; // strobe centred on data
            #(CK_NS / 4);
        end
        #(CK_NS / 4); // strobe stays low as postamble
        busy--;
        if (busy == 0) begin
            dq_o = ~dq_o; // released: stale data must not look valid
        end
    endtask
    always @(posedge ck_i) begin
        if (!cmd_i.cs_n && cmd_i.rcw == RCW_ACT) begin
            if ($time < ready_t[cmd_i.ba]) act_early++;
            act_t[cmd_i.ba] = $time;
        end
        if (!cmd_i.cs_n && cmd_i.rcw == RCW_PRE) begin
            ready_t[cmd_i.ba] = $time + T_RP_NS;
        end
        if (!cmd_i.cs_n && cmd_i.rcw == RCW_RD) begin
            busy++;
            if (cmd_i.addr[A10_BIT]) begin
                // internal precharge point, pushed out as the limits ask
                p_at = $time + (AL + PRE_MIN_CK) * CK_NS;
                if (RTP_CK > PRE_MIN_CK) begin
                    p_at = $time + (AL + RTP_CK) * CK_NS;
                end
                if (p_at < act_t[cmd_i.ba] + RAS_CK * CK_NS) begin
                    p_at = act_t[cmd_i.ba] + RAS_CK * CK_NS;
                end
                ready_t[cmd_i.ba] = p_at + T_RP_NS;
            end
            fork
                burst(cmd_i.addr[7:0], cmd_i.addr[A12_BIT]);
            join_none
        end
    end
endmodule // ddrrd_dev

// *** ddrrd_host_tb_top.sv ***
// self-checking bench: read-path host against a device model
`timescale 1ns/10ps
module ddrrd_host_tb_top
    import ddrrd_pkg::*;
;
    localparam int CL = 5;
    localparam int AL = 0;
    localparam int CWL = 5;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic [1:0] mode = BLM_FIX8;
    ddrrd_req_t req = '0;
    logic req_ready, rd_valid, ck, ck_n, cke, dqs;
    logic [15:0] rd_data;
    logic [7:0] dq;
    ddrrd_cmd_t cmd;
    int err_total = 0;
    int samples_checked = 0;
    logic [31:0] rs = 32'h0000dcca;
    logic [15:0] exp_q[$];
    time t_take;
    ddrrd_kind_t k1[6] = '{DDRRD_RD, DDRRD_RD, DDRRD_RD, DDRRD_PRE,
        DDRRD_PRE, DDRRD_RD};
    ddrrd_kind_t k2[6] = '{DDRRD_RD, DDRRD_WR, DDRRD_PRE, DDRRD_PRE,
        DDRRD_ACT, DDRRD_ACT};
    int gap[6] = '{CCD_CK, CL + AL + CCD_CK - CWL + RW_EXTRA_CK,
        (AL + RTP_CK > PRE_MIN_CK) ? AL + RTP_CK : PRE_MIN_CK, 1, RP_CK,
        AL + RTP_RP_CK};
    ddrrd_host #(.CL(CL), .AL(AL), .CWL(CWL)) dut (.mclk_i(mclk),
        .rst_n_i(rst_n), .req_valid_i(req_valid), .req_i(req),
        .req_ready_o(req_ready), .mode_bl_i(mode), .rd_valid_o(rd_valid),
        .rd_data_o(rd_data), .ck_o(ck), .ck_n_o(ck_n), .cke_o(cke),
        .cmd_o(cmd), .dqs_i(dqs), .dq_i(dq));
    ddrrd_dev #(.RL(CL + AL), .AL(AL)) dev (.ck_i(ck), .cmd_i(cmd),
        .mode_i(mode),
        .dqs_o(dqs), .dq_o(dq));
    initial begin
        forever #20 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic err(input string m);
        err_total++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic check_val(input integer got, input integer exp);
        samples_checked++;
        if (got !== exp) err("count or spacing mismatch");
    endtask
    task automatic check_pair(input logic [15:0] got);
        samples_checked++;
        if (exp_q.size() == 0) err("unexpected read pair");
        else if (got !== exp_q.pop_front()) err("read pair mismatch");
    endtask
    task automatic issue(input ddrrd_kind_t k, input logic [2:0] b,
            input logic ap, input logic b8);
        int n;
        logic [7:0] c;
        n = 0;
        c = 8'(rnd());
        req = '{kind: k, bank: b, addr: {1'b0, b8, 1'b0, ap, 2'h0, c},
            ap: ap, bl8: b8};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 100) err("request never taken");
        @(posedge mclk);
        t_take = $time;
        n = (mode == BLM_FIX8 || (mode == BLM_OTF && b8)) ? 8 : 4;
        for (int i = 0; i < n && k == DDRRD_RD; i += 2) begin
            exp_q.push_back({c + 8'(i + 1), c + 8'(i)});
        end
        #1;
    endtask
    task automatic quiet(input int n);
        req_valid = 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(negedge mclk) begin
        if (rd_valid === 1'b1) check_pair(rd_data);
    end
    initial begin
        #200000;
        err("watchdog expired");
        end_sim();
    end
    initial begin
        repeat (2) @(posedge mclk);
        #1 rst_n = 1'b1;
        for (int m = 0; m < 3; m++) begin
            mode = 2'(m);
            for (int j = 0; j < 6; j++) begin
                issue(DDRRD_RD, 3'(rnd()), 1'(rnd()), 1'(rnd()));
            end
            quiet(200);
            check_val(exp_q.size(), 0);
            $display("test burst mode %0d done", m);
        end
        for (int i = 0; i < 6; i++) begin
            time t0;
            issue(k1[i], 3'(i), i == 5, 1'b1);
            t0 = t_take;
            issue(k2[i], 3'(i), 1'b0, 1'b1);
            quiet(40);
            check_val(int'((t_take - t0) / CK_NS), gap[i]);
        end
        quiet(200);
        check_val(exp_q.size(), 0);
        check_val(dev.act_early, 0);
        $display("test command spacing done");
        end_sim();
    end
endmodule // ddrrd_host_tb_top
bind ddrrd_host ddrrd_chk #(.CL(CL), .AL(AL), .CWL(CWL)) chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .mode_bl_i(mode_bl_i),
    .rd_valid_o(rd_valid_o), .cke_o(cke_o), .ck_o(ck_o), .ck_n_o(ck_n_o),
    .cmd_o(cmd_o),
    .dqs_i(dqs_i));
